/* src/lsa_pkg.sv */
/*
 * Constants and types for the load/store address and alignment block.
 * Assumes a single core clock domain and a pipeline that issues one request per cycle.
 */
// Operation
// - Addresses wrap modulo the logical space; overflow itself never faults.
// - Logical address space is linear, 32 or 64 bits wide.
// - Load/store address is base register plus sign-extended 16-bit displacement.
// - Update form writes the computed address back into the base register.
// - Branch target is PC plus sign-extended 26-bit offset.
// - With delay-slot flag set, the next instruction runs before the target.
// - Operand sizes are byte, halfword, word and doubleword; doubles and vectors 8.
// - Default order is big-endian: lowest address holds the most significant byte.
// - Little-endian enable switches multi-byte accesses to little-endian order.
// - Integer and float operands follow the same byte order.
// - Operand is aligned when its address is a multiple of its length.
// - Misaligned load or store raises an alignment exception; the code raises it only while misalign_ok_i is low.
// - Instructions are 32-bit units fetched from word-aligned addresses.
package lsa_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int LANES = 8;
	localparam int DISP_W = 16;
	localparam int BOFS_W = 26;
	localparam int INSN_BYTES = 4;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_DBL = 2'h3;
	localparam logic [2:0] ALIGN_MASK_HALF = 3'h1;
	localparam logic [2:0] ALIGN_MASK_WORD = 3'h3;
	localparam logic [2:0] ALIGN_MASK_DBL = 3'h7;
	localparam logic [1:0] INSN_ALIGN_MASK = 2'h3;

	typedef enum logic [1:0] {
		LSA_OP_NONE,
		LSA_OP_LOAD,
		LSA_OP_STORE
	} lsa_op_t;

	typedef struct packed {
		lsa_op_t op;
		logic [1:0] size;
		logic update;
		logic [ADDR_W-1:0] base;
		logic [DISP_W-1:0] disp;
		logic [DATA_W-1:0] wdata;
	} lsa_req_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_en;
		logic [DATA_W-1:0] wdata;
	} lsa_mem_t;
endpackage : lsa_pkg

/* src/lsa_lane.sv */
/*
 * Byte-lane steering: places an operand on the 64-bit memory bus and builds lane enables.
 * Assumes lane 0 is the lowest byte address of an 8-byte aligned bus beat.
 */
`timescale 1ns/1ps
module lsa_lane (
	input wire logic [1:0] size_i, // Operand size code.
	input wire logic [2:0] ofs_i, // Low address bits.
	input wire logic le_i, // Little-endian order selected.
	input wire logic [63:0] data_i, // Operand, right-justified.
	output logic [7:0] lane_o, // Byte-lane enables.
	output logic [63:0] data_o // Data steered onto bus lanes.
);
	import lsa_pkg::*;
	logic [3:0] nbytes;
	always_comb begin
		nbytes = 4'h1 << size_i;
		lane_o = 8'h00;
		data_o = 64'h0000_0000_0000_0000;
		for (int i = 0; i < 8; i++) begin
			// Byte i of the operand counts from the least significant end.
			if (i < nbytes) begin
				// Big-endian puts the most significant byte at the lowest address.
				if (le_i) begin
					lane_o[(ofs_i + i) % 8] = 1'b1;
					data_o[((ofs_i + i) % 8)*8 +: 8] = data_i[i*8 +: 8];
				end else begin
					lane_o[(ofs_i + nbytes - 1 - i) % 8] = 1'b1;
					data_o[((ofs_i + nbytes - 1 - i) % 8)*8 +: 8] = data_i[i*8 +: 8];
				end
			end
		end
	end
endmodule : lsa_lane

/* src/lsa_top.sv */
/*
 * Effective-address, branch-target, byte-order and alignment block of a load/store core.
 * Assumes the pipeline holds each request for one cycle and reacts to registered results.
 */
`timescale 1ns/1ps
module lsa_top #(
	parameter int AW = lsa_pkg::ADDR_W
) (
	input wire logic clk_i, // Core clock, 250 MHz.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire lsa_pkg::lsa_req_t req_i, // Load/store request.
	input wire logic little_endian_enable_i, // Supervision register byte-order bit.
	input wire logic misalign_ok_i, // Misaligned-access support present.
	input wire logic br_valid_i, // Branch resolved this cycle.
	input wire logic br_taken_i, // Branch is taken.
	input wire logic [AW-1:0] pc_i, // Branch instruction address.
	input wire logic [lsa_pkg::BOFS_W-1:0] br_ofs_i, // Branch offset field.
	input wire logic delay_slot_config_flag_i, // Delay slot enabled.
	input wire logic [AW-1:0] fetch_addr_i, // Fetch address to check.
	input wire logic fetch_valid_i, // Fetch address valid.
	output lsa_pkg::lsa_mem_t mem_o, // Memory request.
	output logic wb_valid_o, // Base register write-back.
	output logic [AW-1:0] wb_addr_o, // Write-back value.
	output logic align_exc_o, // Alignment exception pulse.
	output logic [AW-1:0] exc_addr_o, // Faulting effective address.
	output logic redirect_o, // Fetch redirect pulse.
	output logic [AW-1:0] target_o, // Redirect target.
	output logic slot_o, // Redirect deferred by a delay slot.
	output logic fetch_exc_o // Misaligned fetch pulse.
);
	import lsa_pkg::*;

	logic [AW-1:0] ea;
	logic [AW-1:0] btgt;
	logic [2:0] amask;
	logic misal;
	logic is_mem;
	logic [7:0] lanes;
	logic [63:0] steered;
	logic pend;
	logic [AW-1:0] pend_tgt;

	// The sum is kept at the address width, so a carry out wraps through zero.
	assign ea = AW'(req_i.base) + {{(AW-DISP_W){req_i.disp[DISP_W-1]}}, req_i.disp};
	assign btgt = pc_i + {{(AW-BOFS_W){br_ofs_i[BOFS_W-1]}}, br_ofs_i};
	assign is_mem = (req_i.op != LSA_OP_NONE);

	always_comb begin
		unique case (req_i.size)
			SZ_BYTE: amask = 3'h0;
			SZ_HALF: amask = ALIGN_MASK_HALF;
			SZ_WORD: amask = ALIGN_MASK_WORD;
			SZ_DBL: amask = ALIGN_MASK_DBL;
		endcase
	end
	assign misal = ((ea[2:0] & amask) != 3'h0) && !misalign_ok_i;

	lsa_lane u_lane (
		.size_i(req_i.size),
		.ofs_i(ea[2:0]),
		.le_i(little_endian_enable_i),
		.data_i(req_i.wdata),
		.lane_o(lanes),
		.data_o(steered)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_o <= '0;
		end else begin
			mem_o.valid <= is_mem && !misal;
			mem_o.write <= (req_i.op == LSA_OP_STORE);
			mem_o.addr <= ea;
			mem_o.lane_en <= lanes;
			mem_o.wdata <= steered;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_valid_o <= 1'b0;
			wb_addr_o <= '0;
		end else begin
			wb_valid_o <= is_mem && req_i.update && !misal;
			wb_addr_o <= ea;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			align_exc_o <= 1'b0;
			exc_addr_o <= '0;
			fetch_exc_o <= 1'b0;
		end else begin
			align_exc_o <= is_mem && misal;
			if (is_mem && misal) begin
				exc_addr_o <= ea;
			end
			fetch_exc_o <= fetch_valid_i && ((fetch_addr_i[1:0] & INSN_ALIGN_MASK) != 2'h0);
		end
	end

	// A taken branch with the delay slot enabled waits for one more fetch before redirecting.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend <= 1'b0;
			pend_tgt <= '0;
			redirect_o <= 1'b0;
			target_o <= '0;
			slot_o <= 1'b0;
		end else begin
			redirect_o <= 1'b0;
			slot_o <= 1'b0;
			// A new taken branch overrides a pending one, so it is looked at first.
			if (br_valid_i && br_taken_i) begin
				if (delay_slot_config_flag_i) begin
					pend <= 1'b1;
					pend_tgt <= btgt;
				end else begin
					pend <= 1'b0;
					redirect_o <= 1'b1;
					target_o <= btgt;
				end
			end else if (pend && fetch_valid_i) begin
				pend <= 1'b0;
				redirect_o <= 1'b1;
				target_o <= pend_tgt;
				slot_o <= 1'b1;
			end
		end
	end

	property p_no_req_on_misalign;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && misal) |=> (align_exc_o && !mem_o.valid && !wb_valid_o);
	endproperty
	a_no_req_on_misalign: assert property (p_no_req_on_misalign) else $error("misaligned access issued");

	property p_ea_sum;
		@(posedge clk_i) disable iff (!rst_n_i)
		is_mem |=> (mem_o.addr == $past(req_i.base) + AW'({{16{$past(req_i.disp[15])}}, $past(req_i.disp)}));
	endproperty
	a_ea_sum: assert property (p_ea_sum) else $error("effective address wrong");

	property p_wb;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && req_i.update && !misal) |=> (wb_valid_o && wb_addr_o == mem_o.addr);
	endproperty
	a_wb: assert property (p_wb) else $error("write-back missing");

	property p_align_word;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && req_i.size == SZ_WORD && ea[1:0] == 2'h0) |=> !align_exc_o;
	endproperty
	a_align_word: assert property (p_align_word) else $error("aligned word faulted");

	property p_misal_dbl;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && req_i.size == SZ_DBL && ea[2:0] != 3'h0 && !misalign_ok_i) |=> align_exc_o;
	endproperty
	a_misal_dbl: assert property (p_misal_dbl) else $error("misaligned double missed");

	property p_be_byte0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && !misal && !little_endian_enable_i && req_i.size == SZ_WORD && ea[2:0] == 3'h0)
			|=> (mem_o.lane_en == 8'h0F && mem_o.wdata[7:0] == $past(req_i.wdata[31:24]));
	endproperty
	a_be_byte0: assert property (p_be_byte0) else $error("big-endian placement wrong");

	property p_le_byte0;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && !misal && little_endian_enable_i && req_i.size == SZ_WORD && ea[2:0] == 3'h0)
			|=> (mem_o.wdata[7:0] == $past(req_i.wdata[7:0]));
	endproperty
	a_le_byte0: assert property (p_le_byte0) else $error("little-endian placement wrong");

	sequence s_slot_branch;
		br_valid_i && br_taken_i && delay_slot_config_flag_i;
	endsequence
	property p_slot;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_slot_branch |=> !redirect_o;
	endproperty
	a_slot: assert property (p_slot) else $error("delay slot skipped");

	sequence s_slot_fetch;
		fetch_valid_i && !(br_valid_i && br_taken_i);
	endsequence
	property p_slot_redirect;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_slot_branch ##1 s_slot_fetch |=> (redirect_o && slot_o && target_o == $past(btgt, 2));
	endproperty
	a_slot_redirect: assert property (p_slot_redirect) else $error("delayed redirect wrong");

	property p_lane_dbl;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && !misal && req_i.size == SZ_DBL) |=> (mem_o.lane_en == 8'hFF);
	endproperty
	a_lane_dbl: assert property (p_lane_dbl) else $error("double lanes wrong");

	property p_byte_ok;
		@(posedge clk_i) disable iff (!rst_n_i)
		(is_mem && req_i.size == SZ_BYTE) |=> (!align_exc_o && mem_o.valid && $onehot(mem_o.lane_en));
	endproperty
	a_byte_ok: assert property (p_byte_ok) else $error("byte access refused");

	property p_direct;
		@(posedge clk_i) disable iff (!rst_n_i)
		(br_valid_i && br_taken_i && !delay_slot_config_flag_i) |=> (redirect_o && target_o == $past(btgt));
	endproperty
	a_direct: assert property (p_direct) else $error("branch target wrong");

	property p_fetch;
		@(posedge clk_i) disable iff (!rst_n_i)
		(fetch_valid_i && fetch_addr_i[1:0] != 2'h0) |=> fetch_exc_o;
	endproperty
	a_fetch: assert property (p_fetch) else $error("misaligned fetch missed");

	property p_fetch_ok;
		@(posedge clk_i) disable iff (!rst_n_i)
		(fetch_valid_i && fetch_addr_i[1:0] == 2'h0) |=> !fetch_exc_o;
	endproperty
	a_fetch_ok: assert property (p_fetch_ok) else $error("aligned fetch flagged");
endmodule : lsa_top

/* verif/lsa_mem_model.sv */
/*
 * Memory-side partner: accepts every request the block issues and records it.
 * Assumes it is clocked with the block and never stalls, as the block has no backpressure.
 */
`timescale 1ns/1ps
module lsa_mem_model (
	input wire logic clk_i, // Core clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire lsa_pkg::lsa_mem_t mem_i, // Request from the block.
	output logic [lsa_pkg::ADDR_W-1:0] last_addr_o, // Address of the last accepted request.
	output logic [7:0] cnt_o // Requests accepted so far.
);
	import lsa_pkg::*;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_addr_o <= '0;
			cnt_o <= 8'h00;
		end else if (mem_i.valid) begin
			last_addr_o <= mem_i.addr;
			cnt_o <= cnt_o + 8'h01;
		end
	end
endmodule : lsa_mem_model

/* verif/load_store_address_align_test.sv */
/*
 * Self-checking bench for the address, byte-order and alignment block.
 * Assumes registered outputs that answer one cycle after a request is sampled.
 */
`timescale 1ns/1ps
module load_store_address_align_test;
	import lsa_pkg::*;
	logic clk_i = 0, rst_n_i = 0, le = 0, mok = 0, bv = 0, bt = 0, ds = 0, fv = 0;
	logic [31:0] pc = '0, fa = '0, wb_addr, exc_addr, target, m_addr;
	logic [25:0] bofs = '0;
	lsa_req_t req = '0;
	lsa_mem_t mem;
	logic wb_v, aexc, redir, slot, fexc;
	logic [7:0] m_cnt;
	int error_cnt = 0, checks = 0, cyc = 0;
	always #2 clk_i = ~clk_i;
	lsa_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .little_endian_enable_i(le),
		.misalign_ok_i(mok), .br_valid_i(bv), .br_taken_i(bt), .pc_i(pc), .br_ofs_i(bofs),
		.delay_slot_config_flag_i(ds), .fetch_addr_i(fa), .fetch_valid_i(fv), .mem_o(mem),
		.wb_valid_o(wb_v), .wb_addr_o(wb_addr), .align_exc_o(aexc), .exc_addr_o(exc_addr),
		.redirect_o(redir), .target_o(target), .slot_o(slot), .fetch_exc_o(fexc));
	lsa_mem_model mem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_i(mem), .last_addr_o(m_addr),
		.cnt_o(m_cnt));
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	// Issues one request and compares every answer with a value worked out here.
	task automatic ls(input lsa_op_t op, input logic [1:0] sz, input logic upd,
		input logic [31:0] base, input logic [15:0] disp, input logic [63:0] wd);
		logic [31:0] ea;
		logic [7:0] lane;
		logic [63:0] dat;
		logic [7:0] cnt0;
		logic f;
		int n, k;
		ea = base + {{16{disp[15]}}, disp};
		n = 1 << sz;
		f = ((ea[2:0] & 3'(n - 1)) != 3'h0) && !mok;
		lane = '0;
		dat = '0;
		for (int j = 0; j < n; j++) begin
			k = le ? (int'(ea[2:0]) + j) % 8 : (int'(ea[2:0]) + n - 1 - j) % 8;
			lane[k] = 1'b1;
			dat[k*8 +: 8] = wd[j*8 +: 8];
		end
		cnt0 = m_cnt;
		@(posedge clk_i);
		#1;
		req = '{op: op, size: sz, update: upd, base: base, disp: disp, wdata: wd};
		@(posedge clk_i);
		#1;
		req.op = LSA_OP_NONE;
		chk("mem_valid", mem.valid, !f);
		chk("align_exc", aexc, f);
		chk("wb_valid", wb_v, upd && !f);
		if (!f) begin
			chk("lane_en_now", mem.lane_en, lane);
			chk("mem_write", mem.write, op == LSA_OP_STORE);
			chk("wdata_now", mem.wdata, dat);
		end
		@(posedge clk_i);
		#1;
		chk("mem_count", m_cnt - cnt0, !f);
		if (f) chk("exc_addr", exc_addr, ea);
		if (upd && !f) chk("wb_addr", wb_addr, ea);
		if (!f) begin
			chk("addr", m_addr, ea);
		end
	endtask : ls
	task automatic ls_lanes(input logic [7:0] lane, input logic [63:0] dat, input logic st);
		chk("lane_en", mem.lane_en, lane);
		if (st) chk("wdata", mem.wdata, dat);
	endtask : ls_lanes
	task automatic t_be;
		ls(LSA_OP_STORE, SZ_WORD, 1'b0, 32'h0000_0100, 16'hFFFC, 64'h0000_0000_1122_3344);
		ls_lanes(8'hF0, 64'h4433_2211_0000_0000, 1'b1);
		ls(LSA_OP_STORE, SZ_WORD, 1'b0, 32'h0000_0200, 16'h0000, 64'h0000_0000_1122_3344);
		ls_lanes(8'h0F, 64'h0000_0000_4433_2211, 1'b1);
		ls(LSA_OP_LOAD, SZ_DBL, 1'b1, 32'hFFFF_FFF8, 16'h0010, 64'h0);
	endtask : t_be
	task automatic t_le;
		le = 1;
		ls(LSA_OP_STORE, SZ_HALF, 1'b0, 32'h0000_0206, 16'h0000, 64'h0000_0000_0000_A1B2);
		ls(LSA_OP_STORE, SZ_WORD, 1'b0, 32'h0000_0300, 16'h0000, 64'h0000_0000_5566_7788);
		le = 0;
	endtask : t_le
	task automatic t_align;
		for (int s = 0; s < 4; s++) begin
			ls(LSA_OP_STORE, 2'(s), 1'b1, 32'h0000_0201, 16'h0000, 64'h0);
		end
		ls(LSA_OP_LOAD, SZ_DBL, 1'b1, 32'h0000_0204, 16'h0000, 64'h0);
		ls(LSA_OP_LOAD, SZ_WORD, 1'b0, 32'h0000_0200, 16'h0004, 64'h0);
		mok = 1;
		ls(LSA_OP_LOAD, SZ_WORD, 1'b1, 32'h0000_0202, 16'h0000, 64'h0);
		mok = 0;
	endtask : t_align
	task automatic t_branch;
		@(posedge clk_i);
		#1;
		{pc, bofs, bv, bt, ds} = {32'h0000_1000, 26'h3FF_FFFC, 3'b110};
		@(posedge clk_i);
		#1;
		{bv, bt, ds, bofs} = {3'b111, 26'h000_0100};
		chk("redirect", redir, 1'b1);
		chk("target", target, 32'h0000_0FFC);
		chk("slot", slot, 1'b0);
		@(posedge clk_i);
		#1;
		{bv, bt, fv, fa} = {3'b001, 32'h0000_1004};
		chk("redirect", redir, 1'b0);
		@(posedge clk_i);
		#1;
		{fv, ds} = 2'b00;
		chk("redirect", redir, 1'b1);
		chk("slot", slot, 1'b1);
		chk("target", target, 32'h0000_1100);
		chk("fetch_exc", fexc, 1'b0);
	endtask : t_branch
	task automatic t_fetch;
		@(posedge clk_i);
		#1;
		{fv, fa} = {1'b1, 32'h0000_1002};
		@(posedge clk_i);
		#1;
		fv = 0;
		chk("fetch_exc", fexc, 1'b1);
	endtask : t_fetch
	// Reset in mid-run must drop a branch that still waits for its delay slot.
	task automatic t_rst;
		@(posedge clk_i);
		#1;
		{bv, bt, ds} = 3'b111;
		@(posedge clk_i);
		#1;
		{bv, bt, ds, rst_n_i} = 4'b0000;
		@(posedge clk_i);
		#1;
		chk("rst_redirect", redir, 1'b0);
		chk("rst_wb", wb_v, 1'b0);
		{rst_n_i, fv, fa} = {2'b11, 32'h0000_2000};
		@(posedge clk_i);
		#1;
		fv = 0;
		chk("rst_pend", redir, 1'b0);
		chk("rst_slot", slot, 1'b0);
		chk("rst_fetch", fexc, 1'b0);
	endtask : t_rst
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		#1;
		chk("reset_valid", mem.valid, 1'b0);
		rst_n_i = 1;
		t_be();
		t_le();
		t_align();
		t_branch();
		t_fetch();
		t_rst();
		conclude();
	end
endmodule : load_store_address_align_test
